// ### rtl/useq_pkg.sv
package useq_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int INSN_W = 16;
  localparam int RAM_AW = 9;
  localparam int DATA_W = 8;
  localparam int STORE_DEPTH = 1024;
  localparam int RAM_DEPTH = 512;

  // ---------------------------------------------------------------
  // Instruction fields and opcodes
  // ---------------------------------------------------------------
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int NIB_SEL_BIT = 10;
  localparam int REG_SEL_HI = 9;
  localparam int REG_SEL_LO = 8;
  localparam int MASK_HI = 7;
  localparam int MASK_LO = 4;
  localparam int BUF_SEL_BIT = 8;
  localparam logic [4:0] OP_BR_ML = 5'h10;
  localparam logic [4:0] OP_BR_NE_ML = 5'h12;
  localparam logic [4:0] OP_BR_TRUE = 5'h14;
  localparam logic [4:0] OP_BR_FALSE = 5'h16;
  localparam logic [4:0] OP_BR_ZERO = 5'h19;
  localparam logic [4:0] OP_BR_NZERO = 5'h1B;
  localparam logic [5:0] OP6_JUMP = 6'h22;
  localparam logic [6:0] OP7_PRESET = 7'h46;
  localparam logic [7:0] OP8_CTRL_ONE = 8'hEC;
  localparam logic [7:0] OP8_CTRL_TWO = 8'hFC;
  localparam logic [7:0] OP8_ST1_AND = 8'hFB;
  localparam logic [15:0] INSN_STORE_KEEP = 16'h1000;
  localparam logic [15:0] INSN_STORE_INC = 16'h1400;
  localparam logic [7:0] CTRL_HOST_STROBE = 8'h10;

  // ---------------------------------------------------------------
  // Status layout and reset values
  // ---------------------------------------------------------------
  localparam int ST0_AD8_BIT = 2;
  localparam int ST1_CARRY_BIT = 7;
  localparam logic [PC_W-1:0] PRIME_STEP = 10'h000;
  localparam logic [RAM_AW-1:0] RAM_ADDR_RST = 9'h000;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint STROBE_WAIT_S = 10;
  localparam longint STROBE_WAIT_CYC = STROBE_WAIT_S * CLK_HZ;

  // Sequencer phases
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_EXEC = 2'b01
  } phase_t;

endpackage : useq_pkg

// ### rtl/useq_ram_if.sv
`timescale 1ns/100ps
// Port bundle of the buffer RAM
interface useq_ram_if;
  logic we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : useq_ram_if

// ### rtl/useq_mem.sv
`timescale 1ns/100ps
// Synchronous memory, registered read data
module useq_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_in,
  // Port
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // ---------------------------------------------------------------
  // Write, and registered read of the word before the write
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[addr_in] <= wdata_in;
    end
    rdata_out <= mem_r[addr_in];
  end
endmodule : useq_mem

// ### rtl/useq_branch_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - False-low branch: mask zeros meet register zeros
// - False-high variant tests the upper nibble
// - Zero/nonzero branches test eight bits
// - Nibble branch changes only counter bits 3:0
// - Byte branch keeps the current page
// - Jump loads page and byte, anywhere
// - Preset loads buffer address, bit8 selects chip
// - Bit8 high selects work buffer
// - Control forms pass operand to outside logic
// - Control two operand 10 strobes host once
// - Power-on, host reset, format restart at zero
// - Buffer address wraps from all ones
// - Work-buffer preset sets status address flag
// - Status one bit7 is carry and format flag
// - Accumulator store increments or keeps address
// - Motor off after ten seconds with no strobe since restart
// - Mask bits 7:4, register 9:8, bit10 nibble
module useq_branch_ctrl #(
  parameter longint STROBE_WAIT_CYC = useq_pkg::STROBE_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Restart sources
  input wire logic host_reset_in,
  input wire logic format_press_in,
  // Microprogram store load port
  input wire logic store_we_in,
  input wire logic [9:0] store_addr_in,
  input wire logic [15:0] store_data_in,
  // Host side
  input wire logic host_strobe_in,
  input wire logic [7:0] host_data_in,
  output logic host_strobe_out,
  output logic [7:0] host_data_out,
  // External control
  output logic ctrl_valid_out,
  output logic ctrl_form_two_out,
  output logic [7:0] ctrl_operand_out,
  output logic motor_off_out,
  // Visible state
  output logic [9:0] microprogram_counter_out,
  output logic [7:0] status_reg_zero_out,
  output logic [7:0] status_reg_one_out,
  output logic [8:0] ram_addr_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  useq_pkg::phase_t phase_r; // Fetch or execute
  logic [9:0] microprogram_counter_r; // Step counter
  logic [7:0] a_r; // Accumulator
  logic [7:0] k_r; // Second register
  logic [7:0] status_reg_zero_r; // Status zero
  logic [7:0] status_reg_one_r; // Status one
  logic [8:0] ram_addr_r; // Buffer address, bit 8 is the chip select
  logic [15:0] insn; // Store read data
  logic [7:0] ram_rdata; // Buffer read data
  logic [31:0] wait_cnt_r; // Strobe wait timer
  logic waiting_r; // Timer armed
  logic restart; // Restart request
  logic [7:0] sel_reg; // Register picked by bits 9:8
  logic [3:0] nib; // Nibble under test
  logic [3:0] mask; // Mask nibble
  logic cond4; // Nibble test result
  logic take4; // Nibble branch taken
  logic take8; // Byte branch taken
  logic is_jump; // Jump form
  logic is_preset; // Preset form
  logic is_ctrl; // Either control form
  logic is_store; // Accumulator store
  logic store_we; // Store port write
  logic [9:0] store_addr; // Store port address

  useq_ram_if ram_bus ();

  assign restart = host_reset_in | format_press_in;

  // ---------------------------------------------------------------
  // Memories
  // ---------------------------------------------------------------
  // Store is loaded while held in restart, read by the counter otherwise
  assign store_we = store_we_in & restart;
  assign store_addr = store_we ? store_addr_in : microprogram_counter_r;

  useq_mem #(.AW(10), .DW(16)) u_store (
    .clk_in(clk_in),
    .we_in(store_we),
    .addr_in(store_addr),
    .wdata_in(store_data_in),
    .rdata_out(insn)
  );

  useq_mem #(.AW(9), .DW(8)) u_buf (
    .clk_in(clk_in),
    .we_in(ram_bus.we),
    .addr_in(ram_bus.addr),
    .wdata_in(ram_bus.wdata),
    .rdata_out(ram_bus.rdata)
  );
  assign ram_rdata = ram_bus.rdata;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Register picked by bits 9:8
  function automatic logic [7:0] pick_reg(input logic [1:0] s, input logic [7:0] a,
      input logic [7:0] k, input logic [7:0] s0, input logic [7:0] s1);
    unique case (s)
      2'b00: pick_reg = a;
      2'b01: pick_reg = k;
      2'b10: pick_reg = s0;
      2'b11: pick_reg = s1;
    endcase
  endfunction : pick_reg

  always_comb begin
    sel_reg = pick_reg(insn[useq_pkg::REG_SEL_HI:useq_pkg::REG_SEL_LO], a_r, k_r,
        status_reg_zero_r, status_reg_one_r);
    // Bit 10 high takes the upper nibble
    nib = insn[useq_pkg::NIB_SEL_BIT] ? sel_reg[7:4] : sel_reg[3:0];
    mask = insn[useq_pkg::MASK_HI:useq_pkg::MASK_LO];
    cond4 = 1'b0;
    unique case (insn[useq_pkg::OP_HI:useq_pkg::OP_LO])
      useq_pkg::OP_BR_ML: cond4 = (nib == mask);
      useq_pkg::OP_BR_NE_ML: cond4 = (nib != mask);
      useq_pkg::OP_BR_TRUE: cond4 = ((nib & mask) == mask);
      // Every zero in the mask must meet a zero in the nibble
      useq_pkg::OP_BR_FALSE: cond4 = ((nib | mask) == mask);
      default: cond4 = 1'b0;
    endcase
    take4 = cond4;
    take8 = ((insn[15:11] == useq_pkg::OP_BR_ZERO) && (sel_reg == 8'h00)) ||
        ((insn[15:11] == useq_pkg::OP_BR_NZERO) && (sel_reg != 8'h00));
    is_jump = (insn[15:10] == useq_pkg::OP6_JUMP);
    is_preset = (insn[15:9] == useq_pkg::OP7_PRESET);
    is_ctrl = (insn[15:8] == useq_pkg::OP8_CTRL_ONE) ||
        (insn[15:8] == useq_pkg::OP8_CTRL_TWO);
    is_store = (insn == useq_pkg::INSN_STORE_KEEP) || (insn == useq_pkg::INSN_STORE_INC);
  end

  // Buffer write of the accumulator
  assign ram_bus.we = (phase_r == useq_pkg::PH_EXEC) && is_store;
  assign ram_bus.addr = ram_addr_r;
  assign ram_bus.wdata = a_r;

  // ---------------------------------------------------------------
  // Phase: fetch gives the store one cycle to present the step
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_r <= useq_pkg::PH_FETCH;
    end else if (restart) begin
      phase_r <= useq_pkg::PH_FETCH;
    end else begin
      phase_r <= (phase_r == useq_pkg::PH_FETCH) ? useq_pkg::PH_EXEC : useq_pkg::PH_FETCH;
    end
  end

  // ---------------------------------------------------------------
  // Microprogram counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      microprogram_counter_r <= useq_pkg::PRIME_STEP;
    end else if (restart) begin
      microprogram_counter_r <= useq_pkg::PRIME_STEP;
    end else if (phase_r == useq_pkg::PH_EXEC) begin
      if (is_jump) begin
        // Page from bits 9:8, byte from 7:0
        microprogram_counter_r <= insn[9:0];
      end else if (take8) begin
        // Page bits stay put
        microprogram_counter_r <= {microprogram_counter_r[9:8], insn[7:0]};
      end else if (take4) begin
        microprogram_counter_r <= {microprogram_counter_r[9:4], insn[3:0]};
      end else begin
        microprogram_counter_r <= microprogram_counter_r + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Buffer address (its status flag is set in the status zero logic below)
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ram_addr_r <= useq_pkg::RAM_ADDR_RST;
    end else if (phase_r == useq_pkg::PH_EXEC && !restart) begin
      if (is_preset) begin
        // Bit 8 picks work (1) or data (0) buffer
        ram_addr_r <= insn[8:0];
      end else if (insn == useq_pkg::INSN_STORE_INC) begin
        // Nine-bit add: carry out of the top is simply lost
        ram_addr_r <= ram_addr_r + 9'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers A, K and the two status registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      a_r <= useq_pkg::REG_RST;
      k_r <= useq_pkg::REG_RST;
      status_reg_zero_r <= useq_pkg::REG_RST;
      status_reg_one_r <= useq_pkg::REG_RST;
    end else begin
      // Status zero bit 2 follows address bit 8 so loops can test it
      status_reg_zero_r[useq_pkg::ST0_AD8_BIT] <= ram_addr_r[useq_pkg::BUF_SEL_BIT];
      if (format_press_in) begin
        // Carry doubles as the format flag; set wins over any clear
        status_reg_one_r[useq_pkg::ST1_CARRY_BIT] <= 1'b1;
      end else if (phase_r == useq_pkg::PH_EXEC &&
          insn[15:8] == useq_pkg::OP8_ST1_AND) begin
        status_reg_one_r <= status_reg_one_r & insn[7:0];
      end
      if (host_strobe_in) begin
        // Host byte lands in K
        k_r <= host_data_in;
      end
      if (phase_r == useq_pkg::PH_EXEC && !restart && insn[15:8] == 8'hF8) begin
        a_r <= a_r & insn[7:0];
      end else if (phase_r == useq_pkg::PH_EXEC && !restart && insn[15:8] == 8'hC8) begin
        a_r <= a_r | insn[7:0];
      end else if (phase_r == useq_pkg::PH_EXEC && !restart && insn[15:8] == 8'h20) begin
        a_r <= ram_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // External control operands and host strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_valid_out <= 1'b0;
      ctrl_form_two_out <= 1'b0;
      ctrl_operand_out <= 8'h00;
      host_strobe_out <= 1'b0;
      host_data_out <= 8'h00;
    end else begin
      ctrl_valid_out <= (phase_r == useq_pkg::PH_EXEC) && is_ctrl && !restart;
      host_strobe_out <= 1'b0;
      if (phase_r == useq_pkg::PH_EXEC && is_ctrl && !restart) begin
        ctrl_operand_out <= insn[7:0];
        ctrl_form_two_out <= insn[12];
        if (insn[15:8] == useq_pkg::OP8_CTRL_TWO && insn[7:0] == useq_pkg::CTRL_HOST_STROBE) begin
          // Exactly one strobe with the accumulator byte
          host_strobe_out <= 1'b1;
          host_data_out <= a_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobe wait: armed by restart, cleared by a host strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      waiting_r <= 1'b1;
      wait_cnt_r <= 32'h0000_0000;
      motor_off_out <= 1'b0;
    end else if (restart) begin
      waiting_r <= 1'b1;
      wait_cnt_r <= 32'h0000_0000;
    end else if (host_strobe_in) begin
      waiting_r <= 1'b0;
      wait_cnt_r <= 32'h0000_0000;
      motor_off_out <= 1'b0;
    end else if (waiting_r) begin
      if (wait_cnt_r == 32'(STROBE_WAIT_CYC - 1)) begin
        // Host stayed silent too long
        motor_off_out <= 1'b1;
        waiting_r <= 1'b0;
      end else begin
        wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Visible state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      microprogram_counter_out <= useq_pkg::PRIME_STEP;
      status_reg_zero_out <= useq_pkg::REG_RST;
      status_reg_one_out <= useq_pkg::REG_RST;
      ram_addr_out <= useq_pkg::RAM_ADDR_RST;
    end else begin
      microprogram_counter_out <= microprogram_counter_r;
      status_reg_zero_out <= status_reg_zero_r;
      status_reg_one_out <= status_reg_one_r;
      ram_addr_out <= ram_addr_r;
    end
  end

endmodule : useq_branch_ctrl

// ### verif/useq_branch_ctrl_asserts.sv
`timescale 1ns/100ps
module useq_branch_ctrl_asserts #(
  parameter longint STROBE_WAIT_CYC = 50
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Restart and host
  input wire logic host_reset_in,
  input wire logic format_press_in,
  input wire logic host_strobe_in,
  input wire logic host_strobe_out,
  // Control and state
  input wire logic ctrl_valid_out,
  input wire logic ctrl_form_two_out,
  input wire logic [7:0] ctrl_operand_out,
  input wire logic motor_off_out,
  input wire logic [9:0] microprogram_counter_out,
  input wire logic [7:0] status_reg_zero_out,
  input wire logic [7:0] status_reg_one_out,
  input wire logic [8:0] ram_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----
  // Quiet time since the last host strobe
  // ----
  longint quiet_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      quiet_r <= 0;
    end else if (host_strobe_in) begin
      // A host strobe restarts the quiet span
      quiet_r <= 0;
    end else begin
      quiet_r <= quiet_r + 1;
    end
  end
  sequence restart_held;
    host_reset_in ##1 host_reset_in;
  endsequence
  sequence format_held;
    format_press_in ##1 format_press_in;
  endsequence
  // ----
  // Checks
  // ----
  AST_RESTART_ZERO: assert property (restart_held |=> microprogram_counter_out == 10'h000)
    else $error("restart did not hold step zero");
  AST_FORMAT_CARRY: assert property (format_held |=> status_reg_one_out[7])
    else $error("format press left carry clear");
  AST_CTRL_PULSE: assert property (ctrl_valid_out |=> !ctrl_valid_out)
    else $error("control valid held two cycles");
  AST_HOST_STROBE: assert property (host_strobe_out |-> ctrl_form_two_out && ctrl_operand_out == 8'h10)
    else $error("host strobe without its control");
  AST_AD8_FLAG: assert property (status_reg_zero_out[2] == $past(ram_addr_out[8]))
    else $error("buffer flag differs from address bit 8");
  AST_STEP_PACE: assert property ($changed(microprogram_counter_out) && !host_reset_in &&
    !format_press_in |=> $stable(microprogram_counter_out) || microprogram_counter_out == 10'h000)
    else $error("counter moved twice in a row");
  AST_MOTOR_WAIT: assert property ($rose(motor_off_out) |-> quiet_r >= STROBE_WAIT_CYC - 1)
    else $error("motor off too early");
  AST_MOTOR_CLEAR: assert property (host_strobe_in |-> ##2 !motor_off_out)
    else $error("strobe did not clear motor off");
endmodule : useq_branch_ctrl_asserts
bind useq_branch_ctrl useq_branch_ctrl_asserts #(.STROBE_WAIT_CYC(STROBE_WAIT_CYC)) chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .host_reset_in(host_reset_in),
  .format_press_in(format_press_in), .host_strobe_in(host_strobe_in),
  .host_strobe_out(host_strobe_out), .ctrl_valid_out(ctrl_valid_out),
  .ctrl_form_two_out(ctrl_form_two_out), .ctrl_operand_out(ctrl_operand_out),
  .motor_off_out(motor_off_out), .microprogram_counter_out(microprogram_counter_out),
  .status_reg_zero_out(status_reg_zero_out), .status_reg_one_out(status_reg_one_out),
  .ram_addr_out(ram_addr_out));

// ### verif/useq_host_model.sv
`timescale 1ns/100ps
module useq_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bench request
  input wire logic go_in,
  input wire logic [7:0] byte_in,
  // Toward the device
  output logic strobe_out,
  output logic [7:0] data_out,
  // From the device
  input wire logic dev_strobe_in,
  input wire logic [7:0] dev_data_in,
  output logic [7:0] rx_count_out,
  output logic [7:0] rx_byte_out
);
  // One-cycle strobe; data inverts each cycle after it, so the old byte returns every second cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strobe_out <= 1'b0;
      data_out <= 8'h00;
    end else begin
      strobe_out <= go_in;
      data_out <= go_in ? byte_in : ~data_out;
    end
  end
  // Count bytes strobed out by the device
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_count_out <= 8'h00;
    end else if (dev_strobe_in) begin
      rx_count_out <= rx_count_out + 8'h01;
      rx_byte_out <= dev_data_in;
    end
  end
endmodule : useq_host_model

// ### verif/tb_useq_branch_ctrl.sv
`timescale 1ns/100ps
module tb_useq_branch_ctrl;
  // ----
  // Bench state
  // ----
  localparam longint WAIT = 50;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic host_reset_in = 1'b0;
  logic format_press_in = 1'b0;
  logic store_we_in = 1'b0;
  logic [9:0] store_addr_in = 10'h000;
  logic [15:0] store_data_in = 16'h0000;
  logic go = 1'b0;
  logic [7:0] go_byte = 8'h00;
  logic hs_in, hs_out, cv, c2, moff;
  logic [7:0] hd_in, hd_out, cop, st0, st1, rx_n, rx_b;
  logic [9:0] pc;
  logic [8:0] ra;
  logic [8:0] clog [$];
  int n_errors = 0;
  int checked = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (cv === 1'b1) clog.push_back({c2, cop});
  useq_branch_ctrl #(.STROBE_WAIT_CYC(WAIT)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .host_reset_in(host_reset_in), .format_press_in(format_press_in), .store_we_in(store_we_in),
    .store_addr_in(store_addr_in), .store_data_in(store_data_in), .host_strobe_in(hs_in),
    .host_data_in(hd_in), .host_strobe_out(hs_out), .host_data_out(hd_out), .ctrl_valid_out(cv),
    .ctrl_form_two_out(c2), .ctrl_operand_out(cop), .motor_off_out(moff),
    .microprogram_counter_out(pc), .status_reg_zero_out(st0), .status_reg_one_out(st1),
    .ram_addr_out(ra));
  useq_host_model host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go), .byte_in(go_byte),
    .strobe_out(hs_in), .data_out(hd_in), .dev_strobe_in(hs_out), .dev_data_in(hd_out),
    .rx_count_out(rx_n), .rx_byte_out(rx_b));
  // ----
  // Helpers
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Store writes only land while restart is held, so each load raises it
  task automatic load(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_in);
    host_reset_in <= 1'b1;
    store_we_in <= 1'b1;
    store_addr_in <= a;
    store_data_in <= d;
  endtask : load
  task automatic run(input logic [7:0] k);
    @(posedge clk_in);
    store_we_in <= 1'b0;
    host_reset_in <= 1'b0;
    go <= 1'b1;
    go_byte <= k;
    @(posedge clk_in);
    go <= 1'b0;
  endtask : run
  task automatic wait_pc(input logic [9:0] p);
    for (int i = 0; i < 60 && pc !== p; i++) @(negedge clk_in);
    check({6'h00, pc}, {6'h00, p});
  endtask : wait_pc
  task automatic wait_new(input logic [9:0] p);
    logic [9:0] old;
    @(negedge clk_in);
    old = pc;
    for (int i = 0; i < 60 && pc === old; i++) @(negedge clk_in);
    check({6'h00, pc}, {6'h00, p});
  endtask : wait_new
  function automatic logic [9:0] nib_exp(input int op, input logic [3:0] m, r, b);
    logic hit;
    case (op)
      0: hit = (r == m);
      1: hit = (r != m);
      2: hit = ((m & ~r) == 4'h0);
      default: hit = ((~m & r) == 4'h0);
    endcase
    return hit ? {6'h10, b} : 10'h101;
  endfunction : nib_exp
  // ----
  // Scenarios
  // ----
  initial begin
    logic [7:0] k, y, n0;
    logic [3:0] m, b;
    logic [4:0] opc [4];
    logic hi;
    opc = '{useq_pkg::OP_BR_ML, useq_pkg::OP_BR_NE_ML, useq_pkg::OP_BR_TRUE, useq_pkg::OP_BR_FALSE};
    void'($urandom(98826));
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check({6'h00, pc}, 16'h0000);
    check({st0, st1}, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      k = 8'($urandom);
      m = 4'($urandom);
      b = 4'h2 + 4'($urandom % 14);
      hi = i[2];
      if (i % 3 == 0) k = {m, m};
      load(10'h000, 16'h8900);
      load(10'h100, {opc[i % 4], hi, 2'b01, m, b});
      run(k);
      wait_pc(10'h100);
      wait_new(nib_exp(i % 4, m, hi ? k[7:4] : k[3:0], b));
      y = 8'h02 + 8'($urandom % 254);
      if (!i[1]) k = 8'h00;
      load(10'h100, {i[0] ? useq_pkg::OP_BR_NZERO : useq_pkg::OP_BR_ZERO, 3'b101, y});
      run(k);
      wait_pc(10'h100);
      wait_new(((k != 8'h00) == i[0]) ? {2'b01, y} : 10'h101);
    end
    for (int p = 0; p < 4; p++) begin
      y = 8'h01 + 8'($urandom % 255);
      load(10'h000, {useq_pkg::OP6_JUMP, 2'(p), y});
      run(8'h00);
      wait_new({2'(p), y});
    end
    load(10'h000, 16'h8BFF);
    load(10'h3FF, 16'h0000);
    run(8'h00);
    wait_pc(10'h3FF);
    wait_new(10'h000);
    for (int i = 0; i < 4; i++) begin
      y = (i == 0) ? 8'hFF : 8'($urandom);
      hi = (i == 0) | i[0];
      load(10'h000, {useq_pkg::OP7_PRESET, hi, y});
      load(10'h001, useq_pkg::INSN_STORE_INC);
      load(10'h002, useq_pkg::INSN_STORE_KEEP);
      load(10'h003, 16'h8803);
      run(8'h00);
      wait_pc(10'h001);
      check({7'h00, ra}, {7'h00, hi, y});
      // Status flag trails the address register by one cycle
      @(negedge clk_in);
      check({15'h0000, st0[2]}, {15'h0000, hi});
      wait_pc(10'h003);
      check({7'h00, ra}, {7'h00, 9'({hi, y} + 9'h001)});
    end
    clog.delete();
    n0 = rx_n;
    y = 8'($urandom);
    k = (y == 8'h10) ? 8'h11 : y;
    load(10'h000, {useq_pkg::OP8_CTRL_ONE, y});
    load(10'h001, {useq_pkg::OP8_CTRL_TWO, k});
    load(10'h002, {useq_pkg::OP8_CTRL_TWO, useq_pkg::CTRL_HOST_STROBE});
    load(10'h003, 16'h8803);
    run(8'h00);
    wait_pc(10'h003);
    repeat (3) @(negedge clk_in);
    check(16'(clog.size()), 16'h0003);
    check({7'h00, clog[0]}, {8'h00, y});
    check({7'h00, clog[1]}, {8'h01, k});
    check({8'h00, rx_n - n0}, 16'h0001);
    check({8'h00, rx_b}, 16'h0000);
    load(10'h000, 16'hA785);
    load(10'h001, 16'h8801);
    load(10'h005, 16'h8805);
    run(8'h00);
    wait_pc(10'h001);
    @(posedge clk_in);
    format_press_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    format_press_in <= 1'b0;
    @(negedge clk_in);
    check({6'h00, pc}, 16'h0000);
    wait_pc(10'h005);
    // A strobe after priming disarms the motor timer
    run(8'h5A);
    repeat (WAIT + 15) @(negedge clk_in);
    check({15'h0000, moff}, 16'h0000);
    // Host reset re-arms it; stay silent this time
    @(posedge clk_in);
    host_reset_in <= 1'b1;
    @(posedge clk_in);
    host_reset_in <= 1'b0;
    repeat (WAIT - 10) @(negedge clk_in);
    check({15'h0000, moff}, 16'h0000);
    repeat (25) @(negedge clk_in);
    check({15'h0000, moff}, 16'h0001);
    run(8'hA5);
    repeat (4) @(negedge clk_in);
    check({15'h0000, moff}, 16'h0000);
    give_verdict();
  end
  // Whole run needs under 1000 cycles; allow forty times that
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule : tb_useq_branch_ctrl
